// *** sdm_pkg.sv ***
// Constants shared by the system interface clock DLL monitor
package sdm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] RX_TAP_IDX = 10'h096;
  localparam logic [9:0] RX_CS_IDX = 10'h097;
  localparam logic [9:0] TX_TAP_IDX = 10'h09a;
  localparam logic [9:0] TX_CS_IDX = 10'h09b;
  localparam logic [9:0] PAR_CFG_IDX = 10'h09c;
  localparam logic [9:0] PAR_TAP_IDX = 10'h09e;
  localparam logic [9:0] PAR_CS_IDX = 10'h09f;
  localparam logic [9:0] INT_STAT_IDX = 10'h0a0;
  localparam logic [9:0] INT_MASK_IDX = 10'h0a1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS_RUN_BIT = 0;
  localparam int CS_END_BIT = 2;
  localparam int CS_END_EVT_BIT = 5;
  localparam int CS_ACT_BIT = 7;
  localparam int CFG_RSV0_BIT = 0;
  localparam int CFG_RSV1_BIT = 1;
  localparam int CFG_BYPASS_BIT = 4;
  // Interrupt status: bits 2:0 clock activity, bits 5:3 delay end
  localparam int INT_ACT_LSB = 0;
  localparam int INT_END_LSB = 3;
  localparam int INT_W = 6;

  // ----------------------------------------------------------------
  // Reset values and delay line shape
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam int TAP_W = 6;
  localparam logic [5:0] TAP_INIT = 6'h20;
  localparam logic [5:0] TAP_MAX = 6'h3f;
  localparam int HIST_W = 65;

endpackage : sdm_pkg

// *** sdm_dll.sv ***
// One delay-locked loop channel, modelled on the system clock
`timescale 1ns/1ps
module sdm_dll (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clk,
  input wire logic sw_rst,
  input wire logic bypass,
  output logic [5:0] tap_q,
  output logic run_q,
  output logic at_end_q,
  output logic rise_q,
  output logic end_rise_q,
  output logic int_clk_q
);

  // ----------------------------------------------------------------
  // Link clock sampling
  // ----------------------------------------------------------------
  logic s1_q, s2_q, s3_q, lvl_q;
  logic [sdm_pkg::HIST_W-1:0] hist_q;
  wire agree = (s2_q == s3_q);
  wire rise_d = agree & s3_q & ~lvl_q;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= link_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
      rise_q <= rise_d;
    end
  end

  // ----------------------------------------------------------------
  // Phase detector and tap stepping
  // ----------------------------------------------------------------
  wire [6:0] tap_nxt_idx = {1'b0, tap_q} + 7'd1;
  wire tap_hi = hist_q[tap_q];
  wire tap_hi_next = hist_q[tap_nxt_idx];
  // Delayed edge lines up with a real edge: one full period of delay
  wire lock_now = tap_hi & ~tap_hi_next;
  wire step_up = tap_hi;
  wire hit_end = step_up ? (tap_q == sdm_pkg::TAP_MAX) : (tap_q == 6'h00);
  wire decide = rise_d & ~bypass;
  wire end_d = (decide && !lock_now) ? hit_end : at_end_q;

  // Delay line history, tap, lock and end flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= '0;
      tap_q <= sdm_pkg::TAP_INIT;
      run_q <= 1'b0;
      at_end_q <= 1'b0;
      end_rise_q <= 1'b0;
      int_clk_q <= 1'b0;
    end else if (sw_rst) begin
      // Software reset returns the loop to its start
      hist_q <= '0;
      tap_q <= sdm_pkg::TAP_INIT;
      run_q <= 1'b0;
      at_end_q <= 1'b0;
      end_rise_q <= 1'b0;
      int_clk_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[sdm_pkg::HIST_W-2:0], lvl_q};
      if (decide) begin
        if (lock_now) begin
          run_q <= 1'b1;
        end else if (!hit_end) begin
          // One tap per decision, never past either end
          tap_q <= step_up ? tap_q + 6'd1 : tap_q - 6'd1;
        end
      end
      at_end_q <= end_d;
      end_rise_q <= end_d & ~at_end_q;
      // Bypass hands on the undelayed clock and freezes the loop
      int_clk_q <= bypass ? lvl_q : hist_q[tap_q];
    end
  end

endmodule : sdm_dll

// *** sdm_top.sv ***
// Three interface clock DLLs with APB registers and interrupt
// What this block does
// - Any write to a DLL tap status register resets that DLL; data ignored.
// - Parallel DLL reset disrupts its interface until lock returns.
// - Lock status bit 0 sets when the phase detector first locks.
// - Lock bit stays set; only system or software reset clears it.
// - Bit 2 shows the DLL sits at a delay line end.
// - Bit 5 sets on each rise of the delay end bit.
// - Bit 5 clears after its control status register is read.
// - Receive bit 7 sets on receive clock rises, clears on read.
// - Transmit bit 7 sets on transmit clock rises, clears on read.
// - Parallel bit 7 sets on parallel clock rises, clears on read.
// - Bypass low: parallel DLL delays its clock for the internal clock.
// - Bypass high: DLL disabled, undelayed clock used.
// - Two reserved config bits are read/write, reset to zero.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module sdm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_interface_clock,
  input wire logic tx_interface_clock,
  input wire logic parallel_tx_clock,
  output logic rx_int_clk,
  output logic tx_int_clk,
  output logic par_int_clk,
  output logic irq
);

  // ----------------------------------------------------------------
  // DLL channels
  // ----------------------------------------------------------------
  logic [2:0] link_clk;
  logic [2:0] swrst_q;
  logic [7:0] cfg_q;
  logic [5:0] tap [3];
  logic [2:0] run, at_end, rise, end_rise, int_clk;
  logic [2:0] bypass;

  assign link_clk = {parallel_tx_clock, tx_interface_clock, rx_interface_clock};
  assign bypass = {cfg_q[sdm_pkg::CFG_BYPASS_BIT], 2'b00};
  assign rx_int_clk = int_clk[0];
  assign tx_int_clk = int_clk[1];
  assign par_int_clk = int_clk[2];

  // Each loop owns its own sampler and software reset; only pclk and presetn are shared
  for (genvar i = 0; i < 3; i++) begin : g_dll
    sdm_dll u_dll (
      .pclk(pclk),
      .presetn(presetn),
      .link_clk(link_clk[i]),
      .sw_rst(swrst_q[i]),
      .bypass(bypass[i]),
      .tap_q(tap[i]),
      .run_q(run[i]),
      .at_end_q(at_end[i]),
      .rise_q(rise[i]),
      .end_rise_q(end_rise[i]),
      .int_clk_q(int_clk[i])
    );
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [9:0] idx = paddr[11:2];
  wire access = psel & penable & pready;
  wire wr_acc = access & pwrite;
  wire rd_acc = access & ~pwrite;
  wire hit_rx_tap = (idx == sdm_pkg::RX_TAP_IDX);
  wire hit_rx_cs = (idx == sdm_pkg::RX_CS_IDX);
  wire hit_tx_tap = (idx == sdm_pkg::TX_TAP_IDX);
  wire hit_tx_cs = (idx == sdm_pkg::TX_CS_IDX);
  wire hit_cfg = (idx == sdm_pkg::PAR_CFG_IDX);
  wire hit_par_tap = (idx == sdm_pkg::PAR_TAP_IDX);
  wire hit_par_cs = (idx == sdm_pkg::PAR_CS_IDX);
  wire hit_ist = (idx == sdm_pkg::INT_STAT_IDX);
  wire hit_imask = (idx == sdm_pkg::INT_MASK_IDX);
  wire mapped = hit_rx_tap | hit_rx_cs | hit_tx_tap | hit_tx_cs | hit_cfg |
                hit_par_tap | hit_par_cs | hit_ist | hit_imask;
  wire [2:0] hit_tap = {hit_par_tap, hit_tx_tap, hit_rx_tap};
  wire [2:0] hit_cs = {hit_par_cs, hit_tx_cs, hit_rx_cs};

  // Write to a tap register is a reset command, value unused
  wire [2:0] swrst_d = (wr_acc && mapped) ? hit_tap : 3'b000;
  wire [2:0] cs_rd = (rd_acc && mapped) ? hit_cs : 3'b000;

  // ----------------------------------------------------------------
  // Sticky event bits
  // ----------------------------------------------------------------
  logic [2:0] act_q, dend_q;
  logic [5:0] ist_q, imask_q;
  wire ist_rd = rd_acc & hit_ist;
  wire [5:0] ist_set = {end_rise, rise};
  // Set beats clear so an event in the read cycle survives
  wire [2:0] act_d = (act_q & ~cs_rd) | rise;
  wire [2:0] dend_d = (dend_q & ~cs_rd) | end_rise;
  wire [5:0] ist_d = (ist_rd ? 6'h00 : ist_q) | ist_set;
  // Next mask, so the interrupt never lags a mask write by a cycle
  wire [5:0] imask_d = (wr_acc && hit_imask) ? pwdata[5:0] : imask_q;

  // Event bits and interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 3'b000;
      dend_q <= 3'b000;
      ist_q <= 6'h00;
      irq <= 1'b0;
    end else begin
      act_q <= act_d;
      dend_q <= dend_d;
      ist_q <= ist_d;
      irq <= |(ist_d & imask_d);
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Config keeps bypass and the two reserved bits only
  localparam logic [7:0] CFG_WMASK = 8'h13;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= sdm_pkg::CFG_RESET;
      imask_q <= sdm_pkg::MASK_RESET;
      swrst_q <= 3'b000;
    end else begin
      swrst_q <= swrst_d;
      if (wr_acc && hit_cfg) begin
        cfg_q <= pwdata[7:0] & CFG_WMASK;
      end
      if (wr_acc && hit_imask) begin
        imask_q <= pwdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] cs_byte(input logic act, input logic dend,
                                         input logic ae, input logic rn);
    logic [7:0] b;
    b = 8'h00;
    b[sdm_pkg::CS_ACT_BIT] = act;
    b[sdm_pkg::CS_END_EVT_BIT] = dend;
    b[sdm_pkg::CS_END_BIT] = ae;
    b[sdm_pkg::CS_RUN_BIT] = rn;
    return b;
  endfunction : cs_byte

  wire [7:0] rx_cs = cs_byte(act_q[0], dend_q[0], at_end[0], run[0]);
  wire [7:0] tx_cs = cs_byte(act_q[1], dend_q[1], at_end[1], run[1]);
  wire [7:0] par_cs = cs_byte(act_q[2], dend_q[2], at_end[2], run[2]);
  wire [7:0] rd_byte =
    hit_rx_tap ? {2'b00, tap[0]} :
    hit_tx_tap ? {2'b00, tap[1]} :
    hit_par_tap ? {2'b00, tap[2]} :
    hit_rx_cs ? rx_cs :
    hit_tx_cs ? tx_cs :
    hit_par_cs ? par_cs :
    hit_cfg ? cfg_q :
    hit_ist ? {2'b00, ist_q} :
    hit_imask ? {2'b00, imask_q} : 8'h00;

  // One wait state: data and ready come from flops a cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= ~mapped;
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : sdm_top

// *** sdm_checker.sv ***
// Concurrent checks on the ports of the interface clock DLL monitor
`timescale 1ns/1ps
module sdm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Address decode and shadow state
  // ----------------------------------------------------------------
  wire [9:0] idx = paddr[11:2];
  wire mapped = idx inside {sdm_pkg::RX_TAP_IDX, sdm_pkg::RX_CS_IDX, sdm_pkg::TX_TAP_IDX,
    sdm_pkg::TX_CS_IDX, sdm_pkg::PAR_CFG_IDX, sdm_pkg::PAR_TAP_IDX, sdm_pkg::PAR_CS_IDX,
    sdm_pkg::INT_STAT_IDX, sdm_pkg::INT_MASK_IDX};
  wire rd_done = pready && !pwrite;
  logic [7:0] cfg_q;
  logic [5:0] mask_q;
  logic seen_q;
  // Shadow copies; seen_q marks a lock already reported for the receive DLL
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 8'h00;
      mask_q <= 6'h00;
      seen_q <= 1'b0;
    end else if (pready && pwrite) begin
      if (idx == sdm_pkg::PAR_CFG_IDX) cfg_q <= pwdata[7:0] & 8'h13;
      if (idx == sdm_pkg::INT_MASK_IDX) mask_q <= pwdata[5:0];
      if (idx == sdm_pkg::RX_TAP_IDX) seen_q <= 1'b0;
    end else if (rd_done && idx == sdm_pkg::RX_CS_IDX && prdata[0]) begin
      seen_q <= 1'b1;
    end
  end
  a_ready_wait: assert property ($rose(psel) |-> ##[1:4] pready)
    else $error("access not answered in time");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_unmapped_zero: assert property (rd_done && !mapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_cfg_readback: assert property (rd_done && idx == sdm_pkg::PAR_CFG_IDX |->
    prdata[7:0] == cfg_q) else $error("config readback wrong");
  a_irq_masked: assert property (irq |-> mask_q != 6'h00)
    else $error("interrupt with all sources masked");
  a_lock_sticky: assert property (rd_done && idx == sdm_pkg::RX_CS_IDX && seen_q |->
    prdata[0]) else $error("lock bit lost");
  c_refused: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_locked: cover property (rd_done && idx == sdm_pkg::RX_CS_IDX && prdata[0]);
endmodule : sdm_checker
bind sdm_top sdm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

// *** sdm_link_model.sv ***
// Far-side model: the three interface clocks of the cell/packet device
`timescale 1ns/1ps
module sdm_link_model (
  input wire logic run,
  input wire logic slow,
  output logic rx_clk,
  output logic tx_clk,
  output logic par_clk
);
  // Receive and transmit clocks, 125 ns, a quarter period apart; low when stopped
  initial begin
    rx_clk = 1'b0;
    tx_clk = 1'b0;
    // Offset keeps link edges away from the system clock edges
    #1;
    forever begin
      #31.25 rx_clk = run & ~rx_clk;
      #31.25 tx_clk = run & ~tx_clk;
    end
  end
  // Parallel clock; slow mode is too long for the delay line to cover
  initial begin
    par_clk = 1'b0;
    #1;
    forever begin
      #(slow ? 250.0 : 62.5) par_clk = run & ~par_clk;
    end
  end
endmodule : sdm_link_model

// *** testbench.sv ***
// Self-checking bench for the interface clock DLL monitor
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, slow;
  logic rx_c, tx_c, par_c, err;
  logic rx_ic, tx_ic, par_ic;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors, cmp_count;
  sdm_link_model u_link (.run(run), .slow(slow), .rx_clk(rx_c), .tx_clk(tx_c),
    .par_clk(par_c));
  sdm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_interface_clock(rx_c), .tx_interface_clock(tx_c),
    .parallel_tx_clock(par_c), .rx_int_clk(rx_ic), .tx_int_clk(tx_ic),
    .par_int_clk(par_ic), .irq(irq));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk
  // Request held until ready is sampled high, then released
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        errors++;
        conclude();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk("register", rd & {24'h00_0000, m}, {24'h00_0000, e});
  endtask : rchk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    rchk(sdm_pkg::PAR_CFG_IDX, 8'hff, 8'h00);
    rchk(sdm_pkg::RX_TAP_IDX, 8'h3f, 8'h20);
    apb(1'b1, sdm_pkg::PAR_CFG_IDX, 8'hff);
    rchk(sdm_pkg::PAR_CFG_IDX, 8'hff, 8'h13);
    apb(1'b1, sdm_pkg::PAR_CFG_IDX, 8'h00);
    apb(1'b0, 10'h3ff, 8'h00);
    chk("refusal", {rd[30:0], err}, 32'h0000_0001);
  endtask : t_defaults
  task automatic t_lock_activity();
    int hr, ht, hp;
    hr = 0;
    ht = 0;
    hp = 0;
    apb(1'b1, sdm_pkg::INT_MASK_IDX, 8'h3f);
    run <= 1'b1;
    repeat (400) begin
      @(posedge pclk);
      hr += rx_ic;
      ht += tx_ic;
      hp += par_ic;
    end
    chk("irq", irq, 1'b1);
    chk("rx internal clock", hr > 100 && hr < 300, 1'b1);
    chk("tx internal clock", ht > 100 && ht < 300, 1'b1);
    chk("parallel internal clock", hp > 100 && hp < 300, 1'b1);
    // Stop the link first so no late edge refills an activity bit
    run <= 1'b0;
    repeat (40) @(posedge pclk);
    rchk(sdm_pkg::RX_CS_IDX, 8'h81, 8'h81);
    rchk(sdm_pkg::RX_CS_IDX, 8'h80, 8'h00);
    rchk(sdm_pkg::TX_CS_IDX, 8'h80, 8'h80);
    rchk(sdm_pkg::TX_CS_IDX, 8'h80, 8'h00);
    rchk(sdm_pkg::PAR_CS_IDX, 8'h80, 8'h80);
    rchk(sdm_pkg::PAR_CS_IDX, 8'h80, 8'h00);
    rchk(sdm_pkg::RX_CS_IDX, 8'h01, 8'h01);
    rchk(sdm_pkg::TX_CS_IDX, 8'h01, 8'h01);
    rchk(sdm_pkg::INT_STAT_IDX, 8'h07, 8'h07);
    rchk(sdm_pkg::INT_STAT_IDX, 8'h3f, 8'h00);
    chk("irq", irq, 1'b0);
  endtask : t_lock_activity
  task automatic t_soft_reset();
    apb(1'b1, sdm_pkg::RX_TAP_IDX, 8'ha5);
    repeat (3) @(posedge pclk);
    rchk(sdm_pkg::RX_CS_IDX, 8'h01, 8'h00);
    rchk(sdm_pkg::RX_TAP_IDX, 8'h3f, 8'h20);
    rchk(sdm_pkg::TX_CS_IDX, 8'h01, 8'h01);
    // Queue resets after a loop reset are left to the far side's software
    apb(1'b1, sdm_pkg::TX_TAP_IDX, 8'h5a);
    repeat (3) @(posedge pclk);
    rchk(sdm_pkg::TX_CS_IDX, 8'h01, 8'h00);
  endtask : t_soft_reset
  // Bypass freezes the parallel loop and passes the plain clock on
  task automatic t_bypass();
    int hp;
    hp = 0;
    apb(1'b1, sdm_pkg::PAR_CFG_IDX, 8'h10);
    apb(1'b1, sdm_pkg::PAR_TAP_IDX, 8'h00);
    slow <= 1'b1;
    run <= 1'b1;
    repeat (400) begin
      @(posedge pclk);
      hp += par_ic;
    end
    run <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("bypass clock", hp > 100 && hp < 300, 1'b1);
    rchk(sdm_pkg::PAR_TAP_IDX, 8'h3f, {2'b00, sdm_pkg::TAP_INIT});
    rchk(sdm_pkg::PAR_CS_IDX, 8'h05, 8'h00);
    apb(1'b1, sdm_pkg::PAR_CFG_IDX, 8'h00);
  endtask : t_bypass
  // Slow parallel clock drives the tap to the end of the line
  task automatic t_line_end();
    apb(1'b1, sdm_pkg::INT_MASK_IDX, 8'h00);
    slow <= 1'b1;
    run <= 1'b1;
    apb(1'b1, sdm_pkg::PAR_TAP_IDX, 8'h00);
    repeat (4000) @(posedge pclk);
    run <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("irq", irq, 1'b0);
    rchk(sdm_pkg::PAR_TAP_IDX, 8'h3f, 8'h00);
    rchk(sdm_pkg::PAR_CS_IDX, 8'h24, 8'h24);
    rchk(sdm_pkg::PAR_CS_IDX, 8'h24, 8'h04);
    apb(1'b1, sdm_pkg::INT_MASK_IDX, 8'h38);
    repeat (4) @(posedge pclk);
    chk("irq", irq, 1'b1);
  endtask : t_line_end
  // Clock and main sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, run, slow} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_lock_activity();
    t_soft_reset();
    t_bypass();
    t_line_end();
    conclude();
  end
endmodule : testbench
